// [src/vlan_filter_consts.svh]
`ifndef VLAN_FILTER_CONSTS_SVH
`define VLAN_FILTER_CONSTS_SVH
// Sizes of the switch
`define NPORT 8
`define PORT_W 3
`define NDOM 8
`define DOM_W 3
`define MAC_W 48
`define TAG_W 8
`define FIFO_DEPTH 4
// Factory broadcast domain and its reset masks
`define DFLT_DOM 3'h0
`define DOM_RST_MASK 8'h01
// Name rules
`define NAME_LEN_W 4
`define NAME_MAX 4'hc
// Command codes
`define OP_W 3
`define OP_NOP 3'h0
`define OP_ASSIGN 3'h1
`define OP_CREATE 3'h2
`define OP_DELETE 3'h3
`define OP_RENAME 3'h4
`define OP_MON_SET 3'h5
`define OP_MON_CLR 3'h6
`define OP_SET_MAC 3'h7
`endif

// [src/vlan_filter_pkg.sv]
`include "vlan_filter_consts.svh"
package vlan_filter_pkg;
    typedef logic [`DOM_W-1:0] dom_idx_t;
    typedef logic [`NPORT-1:0] port_mask_t;
    typedef enum logic [`OP_W-1:0] {
        OP_NOP     = `OP_NOP,
        OP_ASSIGN  = `OP_ASSIGN,
        OP_CREATE  = `OP_CREATE,
        OP_DELETE  = `OP_DELETE,
        OP_RENAME  = `OP_RENAME,
        OP_MON_SET = `OP_MON_SET,
        OP_MON_CLR = `OP_MON_CLR,
        OP_SET_MAC = `OP_SET_MAC
    } cmd_op_t;
endpackage : vlan_filter_pkg

// [src/frame_fifo.sv]
`timescale 1ns/10ps
module frame_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             not_full_reg;
    logic             not_empty_reg;
    logic             push;
    logic             pop;

    assign in_ready  = not_full_reg;
    assign out_valid = not_empty_reg;
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && not_full_reg;
    assign pop       = not_empty_reg && out_ready;

    // Occupancy after this cycle's push and pop
    always_comb begin
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage has no reset; only the flags guard it
    always_ff @(posedge core_clk) begin
        if (ce && push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and registered full and empty flags
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            cnt_reg       <= '0;
            not_full_reg  <= 1'b1;
            not_empty_reg <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            cnt_reg       <= cnt_next;
            not_full_reg  <= cnt_next != (AW+1)'(DEPTH);
            not_empty_reg <= cnt_next != '0;
        end
    end
endmodule : frame_fifo

// [src/station_addr_mem.sv]
`timescale 1ns/10ps
`include "vlan_filter_consts.svh"
module station_addr_mem
    import vlan_filter_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // Write port
    input  wire logic             wr_en,
    input  wire dom_idx_t         wr_addr,
    input  wire logic [`MAC_W-1:0] wr_data,
    // Read port, data one cycle later
    input  wire logic             rd_en,
    input  wire dom_idx_t         rd_addr,
    output logic [`MAC_W-1:0]     rd_data
);
    logic [`MAC_W-1:0] mem_reg [`NDOM];

    // One station address per domain
    always_ff @(posedge core_clk) begin
        if (ce && wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // Registered read; a same-cycle write is seen next read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (ce && rd_en) begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule : station_addr_mem

// [src/port_vlan_membership_filter.sv]
`timescale 1ns/10ps
`include "vlan_filter_consts.svh"
module port_vlan_membership_filter
    import vlan_filter_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    // Port pins
    input  wire port_mask_t                  link_up_pin,
    input  wire port_mask_t                  module_present_pin,
    // Configuration
    input  wire port_mask_t                  trunk_en,
    input  wire logic [`NPORT*`PORT_W-1:0]   trunk_grp,
    input  wire logic [`NDOM-1:0]            stp_dom_en,
    input  wire logic                        restart,
    // Management command
    input  wire logic                        cmd_valid,
    input  wire logic [`OP_W-1:0]            cmd_op,
    input  wire port_mask_t                  cmd_ports,
    input  wire dom_idx_t                    cmd_dom,
    input  wire logic [`NAME_LEN_W-1:0]      cmd_name_len,
    input  wire logic                        cmd_name_space,
    input  wire logic [`MAC_W-1:0]           cmd_mac,
    output logic                             cmd_done,
    output logic                             cmd_err,
    // Frame descriptors in
    input  wire logic                        in_valid,
    output logic                             in_ready,
    input  wire logic [`PORT_W-1:0]          in_port,
    input  wire logic [`TAG_W-1:0]           in_tag,
    // Forwarding decisions out
    output logic                             out_valid,
    input  wire logic                        out_ready,
    output port_mask_t                       out_mask,
    output logic [`TAG_W-1:0]                out_tag,
    // BPDU source lookup
    input  wire logic                        bpdu_req,
    input  wire dom_idx_t                    bpdu_dom,
    output logic                             bpdu_valid,
    output logic                             bpdu_refused,
    output logic [`MAC_W-1:0]                bpdu_src_mac,
    // Status
    output logic [`NDOM-1:0]                 iface_up,
    output logic [`NDOM-1:0]                 dom_exists,
    output logic [`NDOM-1:0]                 dom_selectable,
    output logic [`NPORT*`DOM_W-1:0]         port_dom,
    output port_mask_t                       port_nodom
);
    localparam int FW = `PORT_W + `TAG_W;

    dom_idx_t           dom_reg [`NPORT];
    port_mask_t         nodom_reg;
    logic [`NDOM-1:0]   exist_reg;
    logic [`NDOM-1:0]   sel_reg;
    logic [`NDOM-1:0]   iface_reg;
    port_mask_t         link_s1;
    port_mask_t         link_s2;
    port_mask_t         pres_s1;
    port_mask_t         pres_s2;
    port_mask_t         pres_s3;
    port_mask_t         pres_rise;
    logic               cmd_done_reg;
    logic               cmd_err_reg;
    logic               cmd_bad;
    logic               cmd_ok;
    logic               name_ok;
    cmd_op_t            op;
    logic               f_valid;
    logic               f_ready;
    logic [FW-1:0]      f_data;
    logic               f_pop;
    logic [`PORT_W-1:0] f_src;
    logic               out_valid_reg;
    port_mask_t         out_mask_reg;
    logic [`TAG_W-1:0]  out_tag_reg;
    logic [`PORT_W-1:0] out_src_reg;
    logic               bpdu_ok;
    logic               bpdu_valid_reg;
    logic               bpdu_refused_reg;

    // Ports currently in domain d; the monitor port is in none
    function automatic port_mask_t members(input dom_idx_t d);
        port_mask_t m;
        m = '0;
        for (int i = 0; i < `NPORT; i++) begin
            m[i] = !nodom_reg[i] && (dom_reg[i] == d);
        end
        return m;
    endfunction : members

    // True when a port mask takes part of a trunk but not all of it
    function automatic logic trunk_split(input port_mask_t m);
        logic s;
        s = 1'b0;
        for (int i = 0; i < `NPORT; i++) begin
            for (int j = 0; j < `NPORT; j++) begin
                if (trunk_en[i] && trunk_en[j] && m[i] != m[j] &&
                    trunk_grp[i*`PORT_W +: `PORT_W] ==
                    trunk_grp[j*`PORT_W +: `PORT_W]) begin
                    s = 1'b1;
                end
            end
        end
        return s;
    endfunction : trunk_split

    // Pins cross into the clock domain through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            link_s1 <= '0;
            link_s2 <= '0;
            pres_s1 <= '0;
            pres_s2 <= '0;
            pres_s3 <= '0;
        end else if (ce) begin
            link_s1 <= link_up_pin;
            link_s2 <= link_s1;
            pres_s1 <= module_present_pin;
            pres_s2 <= pres_s1;
            pres_s3 <= pres_s2;
        end
    end

    assign pres_rise = pres_s2 & ~pres_s3;
    assign op        = cmd_op_t'(cmd_op);
    assign name_ok   = cmd_name_len != '0 && cmd_name_len <= `NAME_MAX &&
                       !cmd_name_space;

    // Command checking; a refused command changes nothing
    always_comb begin
        unique case (op)
            OP_ASSIGN:  cmd_bad = !sel_reg[cmd_dom] || cmd_ports == '0 ||
                                  trunk_split(cmd_ports) ||
                                  |(cmd_ports & nodom_reg);
            OP_CREATE:  cmd_bad = exist_reg[cmd_dom] || !name_ok;
            OP_DELETE:  cmd_bad = cmd_dom == `DFLT_DOM ||
                                  !exist_reg[cmd_dom] ||
                                  |members(cmd_dom);
            OP_RENAME:  cmd_bad = !exist_reg[cmd_dom] || !name_ok;
            OP_MON_SET: cmd_bad = cmd_ports == '0;
            OP_MON_CLR: cmd_bad = cmd_ports == '0;
            OP_SET_MAC: cmd_bad = !exist_reg[cmd_dom];
            default:    cmd_bad = 1'b1;
        endcase
    end

    assign cmd_ok = cmd_valid && !cmd_bad;

    // Command answer, one cycle after the command
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_done_reg <= 1'b0;
            cmd_err_reg  <= 1'b0;
        end else if (ce) begin
            cmd_done_reg <= cmd_valid;
            cmd_err_reg  <= cmd_valid && cmd_bad;
        end
    end

    // Domain table; new domains wait for restart before use
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            exist_reg <= `DOM_RST_MASK;
            sel_reg   <= `DOM_RST_MASK;
        end else if (ce) begin
            if (restart) begin
                sel_reg <= exist_reg;
            end
            if (cmd_ok && op == OP_CREATE) begin
                exist_reg[cmd_dom] <= 1'b1;
            end
            if (cmd_ok && op == OP_DELETE) begin
                exist_reg[cmd_dom] <= 1'b0;
                sel_reg[cmd_dom]   <= 1'b0;
            end
        end
    end

    // Port membership: one index per port, changes act at once
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `NPORT; i++) begin
                dom_reg[i] <= `DFLT_DOM;
            end
            nodom_reg <= '0;
        end else if (ce) begin
            for (int i = 0; i < `NPORT; i++) begin
                if (cmd_ok && cmd_ports[i]) begin
                    if (op == OP_ASSIGN) begin
                        dom_reg[i] <= cmd_dom;
                    end
                    if (op == OP_MON_SET) begin
                        nodom_reg[i] <= 1'b1;
                    end
                    if (op == OP_MON_CLR && nodom_reg[i]) begin
                        nodom_reg[i] <= 1'b0;
                        dom_reg[i]   <= `DFLT_DOM;
                    end
                end
                // Hot-plugged module wins over a same-cycle assignment
                if (pres_rise[i] && !nodom_reg[i]) begin
                    dom_reg[i] <= `DFLT_DOM;
                end
            end
        end
    end

    // Interface state per domain from its members' links
    genvar gd;
    generate
        for (gd = 0; gd < `NDOM; gd++) begin : g_iface
            logic up_reg;
            // Local flop per domain, so no variable is written by two processes
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    up_reg <= 1'b0;
                end else if (ce) begin
                    up_reg <= exist_reg[gd] &&
                              |(members(dom_idx_t'(gd)) & link_s2);
                end
            end
            assign iface_reg[gd] = up_reg;
        end
    endgenerate

    // Descriptor buffer; a stalled output backs up to in_ready
    frame_fifo #(
        .WIDTH(FW),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   ({in_port, in_tag}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign f_ready = !out_valid_reg || out_ready;
    assign f_pop   = f_valid && f_ready;
    assign f_src   = f_data[FW-1 -: `PORT_W];

    // Egress mask: same domain only, never back to the source
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_valid_reg <= 1'b0;
            out_mask_reg  <= '0;
            out_tag_reg   <= '0;
            out_src_reg   <= '0;
        end else if (ce) begin
            if (f_pop) begin
                out_valid_reg <= 1'b1;
                out_mask_reg  <= members(dom_reg[f_src]) &
                                 ~(port_mask_t'(1) << f_src);
                out_tag_reg   <= f_data[`TAG_W-1:0];
                out_src_reg   <= f_src;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end

    // Station addresses, one per domain, also the BPDU source
    assign bpdu_ok = stp_dom_en[bpdu_dom] && exist_reg[bpdu_dom];

    station_addr_mem u_mac (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .wr_en    (cmd_ok && op == OP_SET_MAC),
        .wr_addr  (cmd_dom),
        .wr_data  (cmd_mac),
        .rd_en    (bpdu_req && bpdu_ok),
        .rd_addr  (bpdu_dom),
        .rd_data  (bpdu_src_mac)
    );

    // BPDU answer lines up with the registered memory read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bpdu_valid_reg   <= 1'b0;
            bpdu_refused_reg <= 1'b0;
        end else if (ce) begin
            bpdu_valid_reg   <= bpdu_req && bpdu_ok;
            bpdu_refused_reg <= bpdu_req && !bpdu_ok;
        end
    end

    // Outputs
    assign cmd_done       = cmd_done_reg;
    assign cmd_err        = cmd_err_reg;
    assign out_valid      = out_valid_reg;
    assign out_mask       = out_mask_reg;
    assign out_tag        = out_tag_reg;
    assign bpdu_valid     = bpdu_valid_reg;
    assign bpdu_refused   = bpdu_refused_reg;
    assign iface_up       = iface_reg;
    assign dom_exists     = exist_reg;
    assign dom_selectable = sel_reg;
    assign port_nodom     = nodom_reg;
    generate
        for (gd = 0; gd < `NPORT; gd++) begin : g_pdom
            assign port_dom[gd*`DOM_W +: `DOM_W] = dom_reg[gd];
        end
    endgenerate

    // Checks next to the logic they guard
    no_reflect_a: assert property (@(posedge core_clk) disable iff (!rstn)
        out_valid_reg |-> !out_mask_reg[out_src_reg])
        else $error("egress mask includes ingress port");
    mask_nodom_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (ce && f_pop) |=> (out_mask_reg & $past(nodom_reg)) == '0)
        else $error("monitor port in egress mask");
    default_kept_a: assert property (@(posedge core_clk) disable iff (!rstn)
        exist_reg[`DFLT_DOM] && sel_reg[`DFLT_DOM])
        else $error("default domain missing");
    delete_busy_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (ce && cmd_valid && op == OP_DELETE && |members(cmd_dom))
        |=> cmd_err_reg && exist_reg[$past(cmd_dom)])
        else $error("busy domain deleted");
    name_len_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (ce && cmd_valid && op == OP_CREATE && cmd_name_len > `NAME_MAX)
        |=> cmd_err_reg && $stable(exist_reg))
        else $error("long name accepted");
    mon_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (ce && cmd_valid && op == OP_MON_CLR && cmd_ports[0] && nodom_reg[0])
        |=> !nodom_reg[0] && dom_reg[0] == `DFLT_DOM)
        else $error("monitor clear did not restore default");
    sel_wait_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (ce && cmd_valid && op == OP_ASSIGN && !sel_reg[cmd_dom] && pres_rise == '0)
        |=> cmd_err_reg ##0 $stable(port_dom))
        else $error("unselectable domain assigned");
    bpdu_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (ce && bpdu_req && !stp_dom_en[bpdu_dom])
        |=> bpdu_refused_reg && !bpdu_valid_reg)
        else $error("BPDU answered without spanning tree");
    iface_link_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (ce && link_s2 == '0) |=> iface_reg == '0)
        else $error("interface up with all links down");
endmodule : port_vlan_membership_filter

// [testbench/station_sink.sv]
`timescale 1ns/10ps
module station_sink
    import vlan_filter_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Test control
    input  wire logic       stall,
    // Forwarding decisions
    input  wire logic       out_valid,
    output logic            out_ready,
    input  wire port_mask_t out_mask,
    input  wire logic [7:0] out_tag
);
    port_mask_t mask_q[$];
    logic [7:0] tag_q[$];
    // Ready follows stall one edge late, like a station whose buffer fills
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall;
        end
    end
    // Decisions are only recorded; the station never bridges them onward
    always @(posedge core_clk) begin
        if (rstn && out_valid && out_ready) begin
            mask_q.push_back(out_mask);
            tag_q.push_back(out_tag);
        end
    end
endmodule : station_sink

// [testbench/tb_top.sv]
`timescale 1ns/10ps
module tb_top
    import vlan_filter_pkg::*;
;
    // Stimulus
    logic core_clk = 1'b0, rstn = 1'b0, ce = 1'b1, restart = 1'b0, stall = 1'b0;
    port_mask_t link_up_pin = 8'h00, module_present_pin = 8'h00, trunk_en = 8'h00;
    logic [23:0] trunk_grp = 24'h000000;
    logic [7:0] stp_dom_en = 8'h00, in_tag = 8'h00;
    logic cmd_valid = 1'b0, cmd_name_space = 1'b0, in_valid = 1'b0, bpdu_req = 1'b0;
    logic [2:0] cmd_op = 3'h0, in_port = 3'h0;
    port_mask_t cmd_ports = 8'h00;
    dom_idx_t cmd_dom = 3'h0, bpdu_dom = 3'h0;
    logic [3:0] cmd_name_len = 4'h0;
    logic [47:0] cmd_mac = 48'h0;
    // Observed
    logic cmd_done, cmd_err, in_ready, out_valid, out_ready, bpdu_valid, bpdu_refused;
    port_mask_t out_mask, port_nodom;
    logic [7:0] out_tag, iface_up, dom_exists, dom_selectable;
    logic [47:0] bpdu_src_mac;
    logic [23:0] port_dom;
    // Expected state kept by the bench
    int error_cnt = 0;
    int n_checks = 0;
    dom_idx_t exp_dom [8] = '{default: 3'h0};
    port_mask_t exp_mon = 8'h00;

    port_vlan_membership_filter u_port_vlan_membership_filter (.core_clk, .rstn, .ce,
        .link_up_pin, .module_present_pin, .trunk_en, .trunk_grp, .stp_dom_en, .restart,
        .cmd_valid, .cmd_op, .cmd_ports, .cmd_dom, .cmd_name_len, .cmd_name_space, .cmd_mac,
        .cmd_done, .cmd_err, .in_valid, .in_ready, .in_port, .in_tag, .out_valid, .out_ready,
        .out_mask, .out_tag, .bpdu_req, .bpdu_dom, .bpdu_valid, .bpdu_refused, .bpdu_src_mac,
        .iface_up, .dom_exists, .dom_selectable, .port_dom, .port_nodom);
    station_sink u_station_sink (.core_clk, .rstn, .stall, .out_valid, .out_ready,
        .out_mask, .out_tag);

    always #50 core_clk = ~core_clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic hang();
        error_cnt++;
        give_verdict();
    endtask : hang

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Peers of a port: same domain, not itself, never the monitor port
    function automatic port_mask_t exp_mask(input int p);
        port_mask_t m;
        for (int i = 0; i < 8; i++) m[i] = exp_dom[i] == exp_dom[p] && i != p && !exp_mon[i];
        return m;
    endfunction : exp_mask

    function automatic logic [23:0] exp_pd();
        logic [23:0] v;
        for (int i = 0; i < 8; i++) v[3*i +: 3] = exp_dom[i];
        return v;
    endfunction : exp_pd

    // One command strobe; the answer is registered on the same edge that takes it
    task automatic cmd(input logic [2:0] op, input port_mask_t pm, input dom_idx_t d,
                       input logic e, input logic [3:0] len = 4'h4,
                       input logic sp = 1'b0, input logic [47:0] mac = 48'h0);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_ports <= pm;
        cmd_dom <= d;
        cmd_name_len <= len;
        cmd_name_space <= sp;
        cmd_mac <= mac;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        #1;
        chk(cmd_done, 1'b1);
        chk(cmd_err, e);
    endtask : cmd

    // Descriptor held until an edge that sees in_ready high
    task automatic send(input logic [2:0] p, input logic [7:0] t);
        @(posedge core_clk);
        in_valid <= 1'b1;
        in_port <= p;
        in_tag <= t;
        for (int i = 0; i <= 50; i++) begin
            if (i == 50) hang();
            @(negedge core_clk);
            if (in_ready === 1'b1) break;
        end
        @(posedge core_clk);
        in_valid <= 1'b0;
    endtask : send

    task automatic expect_fwd(input logic [7:0] t, input port_mask_t m);
        for (int i = 0; i <= 50; i++) begin
            if (i == 50) hang();
            @(posedge core_clk);
            #1;
            if (u_station_sink.tag_q.size() > 0) break;
        end
        chk(u_station_sink.tag_q.pop_front(), t);
        chk(u_station_sink.mask_q.pop_front(), m);
    endtask : expect_fwd

    task automatic bpdu(input dom_idx_t d, input logic ok, input logic [47:0] mac);
        @(posedge core_clk);
        bpdu_req <= 1'b1;
        bpdu_dom <= d;
        @(posedge core_clk);
        bpdu_req <= 1'b0;
        #1;
        chk(bpdu_valid, ok);
        chk(bpdu_refused, !ok);
        if (ok) chk(bpdu_src_mac, mac);
    endtask : bpdu

    // Link pins pass a two-flop synchroniser: three cycles, plus margin
    task automatic link(input port_mask_t v, input logic [7:0] e);
        @(posedge core_clk);
        link_up_pin <= v;
        repeat (5) @(posedge core_clk);
        #1;
        chk(iface_up, e);
    endtask : link

    task automatic t_create();
        chk(dom_exists, 8'h01);
        chk(port_dom, 24'h000000);
        cmd(OP_NOP, 8'h00, 3'h0, 1'b1);
        cmd(OP_CREATE, 8'h00, 3'h1, 1'b1, 4'h0);
        cmd(OP_CREATE, 8'h00, 3'h1, 1'b1, 4'hd);
        cmd(OP_CREATE, 8'h00, 3'h1, 1'b1, 4'h5, 1'b1);
        cmd(OP_CREATE, 8'h00, 3'h1, 1'b0, 4'hc);
        chk(dom_selectable, 8'h01);
        cmd(OP_ASSIGN, 8'h0c, 3'h1, 1'b1);
        cmd(OP_RENAME, 8'h00, 3'h0, 1'b0, 4'h7);
        @(posedge core_clk);
        restart <= 1'b1;
        @(posedge core_clk);
        restart <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk(dom_selectable, 8'h03);
    endtask : t_create

    task automatic t_assign();
        cmd(OP_ASSIGN, 8'h0c, 3'h1, 1'b0);
        exp_dom[2] = 3'h1;
        exp_dom[3] = 3'h1;
        chk(port_dom, exp_pd());
        send(3'h2, 8'h21);
        expect_fwd(8'h21, exp_mask(2));
        send(3'h0, 8'h22);
        expect_fwd(8'h22, exp_mask(0));
        @(posedge core_clk);
        trunk_en <= 8'h30;
        trunk_grp <= 24'h009000;
        cmd(OP_ASSIGN, 8'h10, 3'h1, 1'b1);
        cmd(OP_ASSIGN, 8'h30, 3'h1, 1'b0);
        cmd(OP_ASSIGN, 8'h80, 3'h1, 1'b0);
        exp_dom[4] = 3'h1;
        exp_dom[5] = 3'h1;
        exp_dom[7] = 3'h1;
        chk(port_dom, exp_pd());
    endtask : t_assign

    task automatic t_monitor();
        cmd(OP_MON_SET, 8'h81, 3'h0, 1'b0);
        exp_mon = 8'h81;
        chk(port_nodom, 8'h81);
        cmd(OP_ASSIGN, 8'h80, 3'h1, 1'b1);
        send(3'h2, 8'h31);
        expect_fwd(8'h31, exp_mask(2));
        cmd(OP_MON_CLR, 8'h81, 3'h0, 1'b0);
        exp_mon = 8'h00;
        exp_dom[7] = 3'h0;
        chk(port_nodom, 8'h00);
        chk(port_dom, exp_pd());
        cmd(OP_DELETE, 8'h00, 3'h0, 1'b1);
        cmd(OP_DELETE, 8'h00, 3'h1, 1'b1);
        cmd(OP_CREATE, 8'h00, 3'h2, 1'b0, 4'h3);
        cmd(OP_DELETE, 8'h00, 3'h2, 1'b0);
        chk(dom_exists, 8'h03);
    endtask : t_monitor

    task automatic t_status();
        link(8'h04, 8'h02);
        link(8'h05, 8'h03);
        link(8'h00, 8'h00);
        cmd(OP_SET_MAC, 8'h00, 3'h0, 1'b0, 4'h4, 1'b0, 48'h02a0_0000_0010);
        cmd(OP_SET_MAC, 8'h00, 3'h1, 1'b0, 4'h4, 1'b0, 48'h02a0_0000_0011);
        cmd(OP_SET_MAC, 8'h00, 3'h6, 1'b1, 4'h4, 1'b0, 48'h02a0_0000_0016);
        @(posedge core_clk);
        stp_dom_en <= 8'h02;
        bpdu(3'h1, 1'b1, 48'h02a0_0000_0011);
        bpdu(3'h0, 1'b0, 48'h0);
        @(posedge core_clk);
        stp_dom_en <= 8'h03;
        bpdu(3'h0, 1'b1, 48'h02a0_0000_0010);
    endtask : t_status

    // Stalled sink: fill the buffer until it refuses, then drain in order
    task automatic t_fifo();
        int n;
        logic acc;
        n = 0;
        acc = 1'b1;
        @(posedge core_clk);
        stall <= 1'b1;
        in_valid <= 1'b1;
        in_port <= 3'h3;
        in_tag <= 8'h40;
        for (int k = 0; k < 12; k++) begin
            @(negedge core_clk);
            acc = in_ready;
            @(posedge core_clk);
            if (acc) n++;
            in_tag <= 8'h40 + 8'(n);
        end
        in_valid <= 1'b0;
        stall <= 1'b0;
        chk(acc, 1'b0);
        chk(n >= 4, 1'b1);
        for (int k = 0; k < n; k++) expect_fwd(8'h40 + 8'(k), exp_mask(3));
    endtask : t_fifo

    task automatic t_hotplug();
        cmd(OP_ASSIGN, 8'h02, 3'h1, 1'b0);
        @(posedge core_clk);
        module_present_pin <= 8'h02;
        repeat (7) @(posedge core_clk);
        #1;
        chk(port_dom, exp_pd());
    endtask : t_hotplug

    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        t_create();
        t_assign();
        t_monitor();
        t_status();
        t_fifo();
        t_hotplug();
        give_verdict();
    end
endmodule : tb_top
